// *** dv/sffs_host.sv ***
// Host reader model that drains the output queue promptly or with stalls.
`timescale 1ns/1ps
module sffs_host (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic slow_i,
   input  wire logic stop_i,
   output logic      fifo_ready_o = 1'b0
);
   // A slow reader toggles ready so the queue must hold each word until taken.
   // A stopped reader lets the queue fill so the full-queue policy can be exercised.
   always @(posedge clk_i) fifo_ready_o <= rst_n_i && !stop_i && (!slow_i || !fifo_ready_o);
endmodule

// *** dv/sffs_props.sv ***
// Port checker for the slot FIFO format selector.
`timescale 1ns/1ps
module sffs_props (
   input wire logic        clk_sys_i, rst_n_i, reg_wr_i, reg_rd_i,
   input wire logic        smp_valid_i, smp_ready_o, fifo_valid_o, fifo_ready_i,
   input wire logic        first_slot_run_o, second_slot_run_o,
   input wire logic [7:0]  reg_addr_i,
   input wire logic [15:0] reg_wdata_i, reg_rdata_o, fifo_data_o,
   input wire logic [6:0]  fifo_level_o
);
   // ==========================================================================
   // Assertions
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   AST_RUN_A: assert property (reg_wr_i && reg_addr_i == 8'h11 |=> ##1
      first_slot_run_o == $past(reg_wdata_i[0], 2)) else $error("first slot run wrong");
   AST_RUN_B: assert property (reg_wr_i && reg_addr_i == 8'h11 |=> ##1
      second_slot_run_o == $past(reg_wdata_i[5], 2)) else $error("second slot run wrong");
   AST_RD_IDLE: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
      else $error("read data outside read slot");
   AST_TAKE: assert property (smp_valid_i && smp_ready_o |=> !smp_ready_o)
      else $error("ready stayed after take");
   AST_HOLD: assert property (fifo_valid_o && !fifo_ready_i |=>
      fifo_valid_o && $stable(fifo_data_o)) else $error("word not held");
   AST_MAX: assert property (fifo_level_o <= 7'd64) else $error("level above depth");
   AST_STEP: assert property (fifo_level_o <= $past(fifo_level_o) + 7'd1)
      else $error("level jumped");
   // Reset must empty the queue so no stale word is delivered.
   AST_RST: assert property (disable iff (1'b0) !rst_n_i |=> !fifo_valid_o && !smp_ready_o)
      else $error("outputs active after reset");
endmodule
bind sffs_top sffs_props sffs_props_inst (.*);

// *** dv/test_slot_fifo_format_select.sv ***
// Self-checking bench for the slot FIFO format selector.
`timescale 1ns/1ps
`include "sffs_regs.vh"
module test_slot_fifo_format_select;
   logic clk_sys_i, rst_n_i, reg_wr_i, reg_rd_i, smp_valid_i, smp_slot_i, slow, stop;
   logic smp_ready_o, fifo_valid_o, fifo_ready_i, first_slot_run_o, second_slot_run_o;
   logic [7:0]   reg_addr_i;
   logic [15:0]  reg_wdata_i, reg_rdata_o, fifo_data_o, cfg, avg;
   logic [127:0] smp_data_i;
   logic [6:0]   fifo_level_o;
   logic [31:0]  seed = 32'h324c;
   logic [15:0]  exp[$];
   int           fail_count, tests_run, i, k;
   sffs_top sffs_top_inst (.*);
   sffs_host sffs_host_inst (.clk_i(clk_sys_i), .rst_n_i(rst_n_i), .slow_i(slow), .stop_i(stop),
      .fifo_ready_o(fifo_ready_i));
   // ==========================================================================
   // Helpers
   initial begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end
   function [31:0] xs(input [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      return x ^ (x << 5);
   endfunction
   task chk(input [15:0] got, input [15:0] want);
      tests_run++;
      if (got !== want) begin
         fail_count++;
         $display("[ERR] %0t got %h want %h", $time, got, want);
      end
   endtask
   task stop_test;
      $display("tests_run %0d fail_count %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task wr(input [7:0] a, input [15:0] d);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask
   task rd(input [7:0] a, input [15:0] want);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b0;
      @(negedge clk_sys_i);
      chk(reg_rdata_o, want);
      @(posedge clk_sys_i);
   endtask
   task wait_rdy;
      k = 0;
      do @(negedge clk_sys_i); while (!smp_ready_o && ++k < 300);
      if (k >= 300) begin
         fail_count++;
         stop_test;
      end
      @(posedge clk_sys_i);
   endtask
   // Reference model: predicts the words a sample leaves in the queue.
   task send(input slot, input [127:0] d);
      logic [31:0] sm;
      logic [2:0]  f;
      f = slot ? cfg[8:6] : cfg[4:2];
      sm = d[31:0] + d[63:32] + d[95:64] + d[127:96];
      if (!(slot ? cfg[5] : cfg[0]) || (slot && cfg[4:2] != 0 && avg[10:8] != avg[6:4]))
         f = 3'h0;
      case (f)
         3'h1: exp.push_back(sm[15:0]);
         3'h2: begin
            exp.push_back(sm[31:16]);
            exp.push_back(sm[15:0]);
         end
         3'h4: for (k = 0; k < 4; k++) exp.push_back(d[32*k +: 16]);
         3'h6: if (slot) for (k = 0; k < 8; k++) exp.push_back(d[32*(k/2)+(k%2 ? 0 : 16) +: 16]);
         default: ;
      endcase
      smp_slot_i <= slot;
      smp_data_i <= d;
      smp_valid_i <= 1'b1;
      wait_rdy;
      smp_valid_i <= 1'b0;
      wait_rdy;
   endtask
   // Reader side compares each accepted word with the model.
   always @(negedge clk_sys_i) if (rst_n_i && fifo_valid_o && fifo_ready_i)
      chk(fifo_data_o, exp.size() ? exp.pop_front() : 16'hxxxx);
   // ==========================================================================
   // Main sequence
   initial begin
      {reg_wr_i, reg_rd_i, smp_valid_i, smp_slot_i, slow, stop, reg_addr_i, reg_wdata_i} = '0;
      smp_data_i = '0;
      rst_n_i = 1'b0;
      repeat (2) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      @(posedge clk_sys_i);
      rd(`SFFS_OFF_CONFIG, 16'h5000);
      rd(8'h40, 16'h0000);
      $display("reset and map test done");
      for (i = 0; i < 60; i++) begin
         seed = xs(seed);
         cfg = (seed[15:0] | 16'h1000) & `SFFS_CONFIG_MASK;
         avg = {5'h0, seed[18:16], 1'b0, seed[19] ? seed[18:16] : seed[22:20], 4'h0};
         wr(`SFFS_OFF_CONFIG, cfg);
         wr(`SFFS_OFF_AVG, avg);
         rd(`SFFS_OFF_CONFIG, cfg);
         slow <= seed[23];
         send(seed[24], {xs(seed), xs(~seed), xs(seed + 1), xs(seed ^ 32'h55)});
      end
      k = 0;
      while (exp.size() && k++ < 2000) @(posedge clk_sys_i);
      repeat (3) @(posedge clk_sys_i);
      // Wrap test: reader stopped, hold off, 72 words overrun 64 entries plus output word.
      stop <= 1'b1;
      cfg = 16'h01a0;
      wr(`SFFS_OFF_CONFIG, cfg);
      for (i = 0; i < 9; i++) begin
         seed = xs(seed);
         send(1'b1, {xs(seed), xs(~seed), xs(seed + 1), xs(seed ^ 32'h55)});
      end
      // The output word survives; the oldest queued words are overwritten.
      while (exp.size() > 65) exp.delete(1);
      rd(`SFFS_OFF_STATUS, 16'h00c0);
      $display("wrap test done");
      stop <= 1'b0;
      k = 0;
      while (exp.size() && k++ < 2000) @(posedge clk_sys_i);
      repeat (3) @(negedge clk_sys_i);
      chk(16'(exp.size()), 16'h0000);
      chk({9'h0, fifo_level_o}, 16'h0000);
      $display("random format test done");
      stop_test;
   end
endmodule

// *** hw/sffs_top.v ***
// Slot FIFO format selector with the shared readout queue and its register file.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`include "sffs_regs.vh"

module sffs_top (
   input  wire                     clk_sys_i,
   input  wire                     rst_n_i,
   input  wire [`SFFS_ADDR_W-1:0]  reg_addr_i,
   input  wire [15:0]              reg_wdata_i,
   input  wire                     reg_wr_i,
   input  wire                     reg_rd_i,
   output reg  [15:0]              reg_rdata_o,
   input  wire                     smp_valid_i,
   input  wire                     smp_slot_i,
   input  wire [127:0]             smp_data_i,
   output reg                      smp_ready_o,
   output reg                      fifo_valid_o,
   output reg  [15:0]              fifo_data_o,
   input  wire                     fifo_ready_i,
   output reg  [`SFFS_CNT_W-1:0]   fifo_level_o,
   output reg                      first_slot_run_o,
   output reg                      second_slot_run_o
);

// ==========================================================================
// Registers
reg  [15:0]             cfg;
reg  [15:0]             avg;
reg                     overflow_seen;
reg  [15:0]             mem [0:`SFFS_DEPTH-1];
reg  [`SFFS_PTR_W-1:0]  wr_ptr;
reg  [`SFFS_PTR_W-1:0]  rd_ptr;
reg  [`SFFS_CNT_W-1:0]  count;

wire [2:0] fmt_a = cfg[`SFFS_A_FMT_HI:`SFFS_A_FMT_LO];
wire [2:0] fmt_b = cfg[`SFFS_B_FMT_HI:`SFFS_B_FMT_LO];
wire       hold  = cfg[`SFFS_HOLD_BIT];
wire       avg_match = avg[`SFFS_AVG_B_HI:`SFFS_AVG_B_LO] == avg[`SFFS_AVG_A_HI:`SFFS_AVG_A_LO];

always @(posedge clk_sys_i) begin
   if (!rst_n_i) begin
      cfg <= `SFFS_CONFIG_RST;
      avg <= `SFFS_AVG_RST;
   end else if (reg_wr_i) begin
      if (reg_addr_i == `SFFS_OFF_CONFIG) begin
         cfg <= reg_wdata_i & `SFFS_CONFIG_MASK;
      end else if (reg_addr_i == `SFFS_OFF_AVG) begin
         avg <= reg_wdata_i;
      end
   end
end

always @(posedge clk_sys_i) begin
   if (!rst_n_i) begin
      reg_rdata_o <= 16'h0000;
   end else if (reg_rd_i) begin
      if (reg_addr_i == `SFFS_OFF_CONFIG) begin
         reg_rdata_o <= cfg;
      end else if (reg_addr_i == `SFFS_OFF_AVG) begin
         reg_rdata_o <= avg;
      end else if (reg_addr_i == `SFFS_OFF_STATUS) begin
         reg_rdata_o <= {8'h00, overflow_seen, count};
      end else begin
         reg_rdata_o <= 16'h0000;
      end
   end else begin
      reg_rdata_o <= 16'h0000;
   end
end

// ==========================================================================
// Format selection
function [3:0] word_count;
   input [2:0] fmt;
   begin
      case (fmt)
         `SFFS_FMT_SUM16: word_count = 4'h1;
         `SFFS_FMT_SUM32: word_count = 4'h2;
         `SFFS_FMT_CH16:  word_count = 4'h4;
         `SFFS_FMT_CH32:  word_count = 4'h8;
         default:         word_count = 4'h0;
      endcase
   end
endfunction

// Channel 32-bit format exists only for the second slot.
wire [2:0] eff_a   = (fmt_a == `SFFS_FMT_CH32) ? `SFFS_FMT_NONE : fmt_a;
wire       b_legal = avg_match || (fmt_a == `SFFS_FMT_NONE);
wire       a_on    = cfg[`SFFS_A_EN_BIT];
wire       b_on    = cfg[`SFFS_B_EN_BIT] && b_legal;
wire [2:0] cur_fmt = smp_slot_i ? fmt_b : eff_a;
wire       slot_on = smp_slot_i ? b_on : a_on;

// Sample inputs: four channels of 32 bits, channel 0 in the low bits.
function [15:0] pick_word;
   input [2:0]   fmt;
   input [127:0] d;
   input [2:0]   idx;
   reg   [31:0]  sum;
   begin
      sum = d[31:0] + d[63:32] + d[95:64] + d[127:96];
      case (fmt)
         `SFFS_FMT_SUM16: pick_word = sum[15:0];
         `SFFS_FMT_SUM32: pick_word = idx[0] ? sum[15:0] : sum[31:16];
         `SFFS_FMT_CH16:  pick_word = d[idx[1:0]*32 +: 16];
         default:         pick_word = idx[0] ? d[idx[2:1]*32 +: 16] : d[idx[2:1]*32+16 +: 16];
      endcase
   end
endfunction

// ==========================================================================
// Serialiser: one captured sample is broken into queue words.
reg  [127:0] cap_data;
reg  [2:0]   cap_fmt;
reg  [3:0]   cap_left;
reg  [2:0]   cap_idx;
wire         busy     = cap_left != 4'h0;
wire         full     = count == `SFFS_DEPTH;
wire         take     = smp_valid_i && smp_ready_o;
wire [15:0]  wr_word  = pick_word(cap_fmt, cap_data, cap_idx);
// A held full queue stalls the serialiser so no word is lost.
wire         push     = busy && (!full || !hold);
wire         drop_old = push && full;
wire         pop      = (count != 7'h00) && (!fifo_valid_o || fifo_ready_i) && !drop_old;

always @(posedge clk_sys_i) begin
   if (!rst_n_i) begin
      cap_data    <= 128'h0;
      cap_fmt     <= 3'h0;
      cap_left    <= 4'h0;
      cap_idx     <= 3'h0;
      smp_ready_o <= 1'b0;
   end else begin
      smp_ready_o <= !busy && !take;
      if (take) begin
         cap_data <= smp_data_i;
         cap_fmt  <= cur_fmt;
         cap_idx  <= 3'h0;
         cap_left <= slot_on ? word_count(cur_fmt) : 4'h0;
      end else if (push) begin
         cap_left <= cap_left - 4'h1;
         cap_idx  <= cap_idx + 3'h1;
      end
   end
end

// ==========================================================================
// Queue storage and output buffer
always @(posedge clk_sys_i) begin
   if (push) begin
      mem[wr_ptr] <= wr_word;
   end
end

always @(posedge clk_sys_i) begin
   if (!rst_n_i) begin
      wr_ptr        <= 6'h00;
      rd_ptr        <= 6'h00;
      count         <= 7'h00;
      overflow_seen <= 1'b0;
      fifo_valid_o  <= 1'b0;
      fifo_data_o   <= 16'h0000;
   end else begin
      if (push) begin
         wr_ptr <= wr_ptr + 6'h01;
      end
      if (drop_old) begin
         rd_ptr        <= rd_ptr + 6'h01;
         overflow_seen <= 1'b1;
      end else if (pop) begin
         rd_ptr <= rd_ptr + 6'h01;
      end
      if (push && !pop && !drop_old) begin
         count <= count + 7'h01;
      end else if (pop && !push) begin
         count <= count - 7'h01;
      end
      if (pop) begin
         fifo_valid_o <= 1'b1;
         fifo_data_o  <= mem[rd_ptr];
      end else if (fifo_ready_i) begin
         fifo_valid_o <= 1'b0;
      end
   end
end

always @(posedge clk_sys_i) begin
   if (!rst_n_i) begin
      fifo_level_o      <= 7'h00;
      first_slot_run_o  <= 1'b0;
      second_slot_run_o <= 1'b0;
   end else begin
      fifo_level_o      <= count;
      first_slot_run_o  <= a_on;
      second_slot_run_o <= cfg[`SFFS_B_EN_BIT];
   end
end

endmodule

// *** include/sffs_regs.vh ***
// Register offsets, field positions, reset values and codes for the slot FIFO format selector.
`ifndef SFFS_REGS_VH
`define SFFS_REGS_VH
// ==========================================================================
// Register map
`define SFFS_ADDR_W          8
`define SFFS_OFF_CONFIG      8'h11
`define SFFS_OFF_AVG         8'h15
`define SFFS_OFF_STATUS      8'h16
`define SFFS_CONFIG_RST      16'h5000
`define SFFS_AVG_RST         16'h0000
// ==========================================================================
// Configuration fields
`define SFFS_A_EN_BIT        0
`define SFFS_A_FMT_LO        2
`define SFFS_A_FMT_HI        4
`define SFFS_B_EN_BIT        5
`define SFFS_B_FMT_LO        6
`define SFFS_B_FMT_HI        8
`define SFFS_HOLD_BIT        12
`define SFFS_CONFIG_MASK     16'hf1fd
// Averaging factor fields.
`define SFFS_AVG_A_LO        4
`define SFFS_AVG_A_HI        6
`define SFFS_AVG_B_LO        8
`define SFFS_AVG_B_HI        10
// ==========================================================================
// Format codes
`define SFFS_FMT_NONE        3'h0
`define SFFS_FMT_SUM16       3'h1
`define SFFS_FMT_SUM32       3'h2
`define SFFS_FMT_CH16        3'h4
`define SFFS_FMT_CH32        3'h6
// ==========================================================================
// Queue
`define SFFS_DEPTH           64
`define SFFS_PTR_W           6
`define SFFS_CNT_W           7
`endif
